/* File: src/pm_cap_pkg.sv */
// Purpose: constants and carriers for the power-management capability block
// Assumes: dword-aligned configuration accesses with an 8-bit byte offset
// Notes:   capability fields are constant apart from the revision field
// How it works
// - next pointer bits 15-8 read 00h
// - capability code bits 7-0 read 01h
// - event-capable states bits 15-11 read 01111b
// - bit 10 reads 1b, state two supported
// - bit 9 reads 1b, state one supported
// - auxiliary current bits 8-6 read 000b
// - bit 5 reads 0b, no special initialization
// - reserved bit 4 always reads 0b
// - bit 3 reads 0b, no bus clock needed
// - select bit clear gives revision 010b
// - select bit set gives revision 011b
// - header at 44h, capabilities at 46h
// - select bit reset only by fundamental reset
package pm_cap_pkg;

  // ----------------------------------------------------------------
  // offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] cap_header_offset   = 8'h44;
  localparam logic [7:0] cap_word_offset     = 8'h46;
  localparam logic [7:0] cap_second_offset   = 8'h48;
  localparam logic [7:0] misc_config_offset  = 8'hf0;
  localparam int         revision_select_pos = 7;

  // ----------------------------------------------------------------
  // field values
  // ----------------------------------------------------------------
  localparam logic [7:0] next_item_value      = 8'h00;
  localparam logic [7:0] capability_code      = 8'h01;
  localparam logic [4:0] event_capable_states = 5'h0f;
  localparam logic       state_two_supported  = 1'b1;
  localparam logic       state_one_supported  = 1'b1;
  localparam logic [2:0] aux_current_value    = 3'h0;
  localparam logic       special_init_value   = 1'b0;
  localparam logic       reserved_bit_value   = 1'b0;
  localparam logic       event_needs_bus_clock = 1'b0;
  localparam logic [2:0] revision_one_one     = 3'h2;
  localparam logic [2:0] revision_one_two     = 3'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic        revision_select_reset = 1'b1;
  localparam logic [15:0] cap_header_reset      = 16'h0001;
  localparam logic [15:0] cap_word_reset        = 16'h7e03;
  localparam logic [31:0] read_data_reset       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [31:0] data;
  } cfg_rsp_t;

endpackage

/* File: src/revision_select_store.sv */
// Purpose: holds the revision select bit of the miscellaneous register
// Assumes: arst_n is the fundamental reset, covering bus and global reset
// Notes:   function-level resets do not reach this flop by design
module revision_select_store
  import pm_cap_pkg::*;
(
  // clock and fundamental reset
  input  wire logic     ref_clk,
  input  wire logic     arst_n,
  // configuration request
  input  wire cfg_req_t req,
  // stored bit
  output logic          revision_select_bit
);

  logic sel_reg;
  logic sel_next;

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  always_comb begin
    sel_next = sel_reg;
    if (req.wr && req.addr == misc_config_offset && req.be[0]) begin
      sel_next = req.wdata[revision_select_pos];
    end
  end

  // only the fundamental reset sets this bit back to its reset value of 1
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= revision_select_reset;
    end else begin
      sel_reg <= sel_next;
    end
  end

  assign revision_select_bit = sel_reg;

endmodule

/* File: src/pci_power_mgmt_capability.sv */
// Purpose: read-only power-management capability pair in configuration space
// Assumes: one request per cycle; outer logic merges responses by hit
// Notes:   reads answer one cycle after the request; misc register shows bit 7 only
module pci_power_mgmt_capability
  import pm_cap_pkg::*;
(
  // clock and fundamental reset
  input  wire logic     ref_clk,
  input  wire logic     arst_n,
  // function reset, same clock, leaves the revision select bit alone
  input  wire logic     func_reset,
  // configuration access
  input  wire cfg_req_t req,
  output cfg_rsp_t      rsp,
  // current revision select, for other blocks
  output logic          revision_select_bit
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic hits_cap(input logic [7:0] a);
    hits_cap = (a == cap_header_offset);
  endfunction

  function automatic logic hits_misc(input logic [7:0] a);
    hits_misc = (a == misc_config_offset);
  endfunction

  logic        sel;
  logic [15:0] cap_header;
  logic [15:0] cap_word;
  logic [2:0]  revision;

  revision_select_store u_select (
    .ref_clk             (ref_clk),
    .arst_n              (arst_n),
    .req                 (req),
    .revision_select_bit (sel)
  );

  assign revision_select_bit = sel;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  always_comb begin
    revision = sel ? revision_one_two : revision_one_one;
    cap_header = {next_item_value, capability_code};
    cap_word = {event_capable_states,
                state_two_supported,
                state_one_supported,
                aux_current_value,
                special_init_value,
                reserved_bit_value,
                event_needs_bus_clock,
                revision};
  end

  // ----------------------------------------------------------------
  // read response
  // ----------------------------------------------------------------
  cfg_rsp_t rsp_reg;
  cfg_rsp_t rsp_next;

  // writes to 44h never touch the capability fields; all but the revision are constants
  always_comb begin
    rsp_next.valid = req.rd;
    rsp_next.hit = 1'b0;
    rsp_next.data = read_data_reset;
    if (req.rd && hits_cap(req.addr)) begin
      rsp_next.hit = 1'b1;
      rsp_next.data = {cap_word, cap_header};
    end else if (req.rd && hits_misc(req.addr)) begin
      rsp_next.hit = 1'b1;
      rsp_next.data[revision_select_pos] = sel;
    end
    if (func_reset) begin
      rsp_next.valid = 1'b0;
      rsp_next.hit = 1'b0;
      rsp_next.data = read_data_reset;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_next_pointer_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset |=> rsp.data[15:8] == 8'h00)
    else $error("next pointer not zero");

  a_code_is_one: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset |=> rsp.valid && rsp.hit && rsp.data[7:0] == 8'h01)
    else $error("capability code wrong");

  a_event_states: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset |=> rsp.data[31:27] == 5'b01111)
    else $error("event states field wrong");

  a_state_two: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset |=> rsp.data[26])
    else $error("state two flag clear");

  a_state_one: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset |=> rsp.data[25])
    else $error("state one flag clear");

  a_low_flags_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset |=> rsp.data[24:22] == 3'b000)
    else $error("aux current not zero");

  a_init_flag_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset |=> !rsp.data[21])
    else $error("init flag set");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset |=> !rsp.data[20])
    else $error("reserved bit set");

  a_clock_flag_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset |=> !rsp.data[19])
    else $error("bus clock flag set");

  a_revision_old: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset && !sel |=> rsp.data[18:16] == 3'b010)
    else $error("revision not 010b");

  a_revision_new: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset && sel |=> rsp.data[18:16] == 3'b011)
    else $error("revision not 011b");

  a_map_decode: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && !hits_cap(req.addr) && !hits_misc(req.addr) |=> !rsp.hit && rsp.data == 32'h0)
    else $error("unmapped offset answered");

  a_select_keeps: assert property (@(posedge ref_clk) disable iff (!arst_n)
    func_reset && !(req.wr && hits_misc(req.addr)) |=> $stable(sel))
    else $error("select bit moved without a write");

  a_write_ignored: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.wr && hits_cap(req.addr) ##1 req.rd && hits_cap(req.addr) && !func_reset
      |=> rsp.data[15:0] == 16'h0001 && rsp.data[31:19] == 13'h0fc0)
    else $error("capability write took effect");

  // a read and a write to the misc register in one cycle return the pre-write bit
  a_misc_shows_bit: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_misc(req.addr) && !func_reset
      |=> rsp.data[7] == $past(sel) && rsp.data[31:8] == 24'h000000 && rsp.data[6:0] == 7'h00)
    else $error("misc read does not show select bit");

  // ----------------------------------------------------------------
  // handshake and select bit checks
  // ----------------------------------------------------------------
  // every read outside function reset gets one answer, so the outer merge can count them
  a_read_answered: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && !func_reset
      |=> rsp.valid)
    else $error("read got no answer");

  // the answer stands one cycle only; a stale hit would shadow other blocks
  a_idle_silent: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !req.rd
      |=> !rsp.valid && !rsp.hit && rsp.data == 32'h0000_0000)
    else $error("answer without a read");

  a_func_blanks: assert property (@(posedge ref_clk) disable iff (!arst_n)
    func_reset
      |=> !rsp.valid && !rsp.hit && rsp.data == 32'h0000_0000)
    else $error("answer during function reset");

  a_misc_hit: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_misc(req.addr) && !func_reset
      |=> rsp.valid && rsp.hit)
    else $error("misc read not claimed");

  a_unmapped_valid: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && !hits_cap(req.addr) && !hits_misc(req.addr) && !func_reset
      |=> rsp.valid && !rsp.hit)
    else $error("unmapped read not answered as a miss");

  a_header_value: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset
      |=> rsp.data[15:0] == cap_header_reset)
    else $error("header half differs from its fixed value");

  a_word_default: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.rd && hits_cap(req.addr) && !func_reset && sel
      |=> rsp.data[31:16] == cap_word_reset)
    else $error("capabilities half differs from its default");

  a_select_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.wr && hits_misc(req.addr) && req.be[0] && req.wdata[7]
      |=> sel)
    else $error("select bit not set by write");

  a_select_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req.wr && hits_misc(req.addr) && req.be[0] && !req.wdata[7]
      |=> !sel)
    else $error("select bit not cleared by write");

  a_select_steady: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !(req.wr && hits_misc(req.addr) && req.be[0])
      |=> $stable(sel))
    else $error("select bit moved without a write");

  // no disable here: it watches the outputs while the fundamental reset is held;
  // the first reset edge is skipped so the time-zero reset event cannot race it
  a_reset_quiet: assert property (@(posedge ref_clk)
    !arst_n ##1 !arst_n
      |-> !rsp.valid && !rsp.hit && sel)
    else $error("outputs not at reset values");

endmodule

/* File: testbench/pci_power_mgmt_capability_tb.sv */
// Purpose: self-checking bench for the read-only power-management capability pair
// Assumes: one request per cycle, read answer one cycle after the request edge
// Notes:   inputs change on the falling edge, responses are sampled there too
module pci_power_mgmt_capability_tb
  import pm_cap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic     ref_clk;
  logic     arst_n;
  logic     func_reset;
  cfg_req_t req;
  cfg_rsp_t rsp;
  logic     revision_select_bit;
  int       mismatches;
  int       checks_done;
  int       cycles;

  pci_power_mgmt_capability dut (
    .ref_clk             (ref_clk),
    .arst_n              (arst_n),
    .func_reset          (func_reset),
    .req                 (req),
    .rsp                 (rsp),
    .revision_select_bit (revision_select_bit)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // expected dword at 44h, built field by field from the capability layout
  function automatic logic [31:0] cap_dword(input logic sel);
    return {5'b01111, 1'b1, 1'b1, 3'b000, 1'b0, 1'b0, 1'b0, (sel ? 3'b011 : 3'b010), 8'h00, 8'h01};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // read held for one edge; answer is looked at in the cycle it stands
  task automatic rd(input logic [7:0] addr, input logic hit, input logic [31:0] data);
    req.rd   = 1'b1;
    req.addr = addr;
    @(negedge ref_clk);
    req.rd = 1'b0;
    check("rsp.valid", 32'(rsp.valid), 32'h1);
    check("rsp.hit", 32'(rsp.hit), 32'(hit));
    check("rsp.data", rsp.data, data);
    @(negedge ref_clk);
    check("rsp.valid after", 32'(rsp.valid), 32'h0);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] wdata);
    req.wr    = 1'b1;
    req.addr  = addr;
    req.be    = be;
    req.wdata = wdata;
    @(negedge ref_clk);
    req.wr = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values;
    check("select after reset", 32'(revision_select_bit), 32'h1);
    rd(8'h44, 1'b1, cap_dword(1'b1));
    $display("test reset_values done");
  endtask

  task automatic test_write_ignored;
    wr(8'h44, 4'hf, 32'hffff_ffff);
    wr(8'h44, 4'hf, 32'h0000_0000);
    rd(8'h44, 1'b1, cap_dword(1'b1));
    rd(8'h44, 1'b1, cap_dword(1'b1));
    $display("test write_ignored done");
  endtask

  task automatic test_revision_select;
    wr(8'hf0, 4'h1, 32'h0000_0000);
    check("select cleared", 32'(revision_select_bit), 32'h0);
    rd(8'h44, 1'b1, cap_dword(1'b0));
    rd(8'hf0, 1'b1, 32'h0000_0000);
    wr(8'hf0, 4'h0, 32'hffff_ffff);
    rd(8'h44, 1'b1, cap_dword(1'b0));
    wr(8'hf0, 4'h1, 32'h0000_0080);
    rd(8'h44, 1'b1, cap_dword(1'b1));
    rd(8'hf0, 1'b1, 32'h0000_0080);
    $display("test revision_select done");
  endtask

  task automatic test_resets;
    wr(8'hf0, 4'h1, 32'h0000_0000);
    func_reset = 1'b1;
    req.rd     = 1'b1;
    req.addr   = 8'h44;
    @(negedge ref_clk);
    req.rd     = 1'b0;
    func_reset = 1'b0;
    check("valid under func reset", 32'(rsp.valid), 32'h0);
    check("hit under func reset", 32'(rsp.hit), 32'h0);
    check("data under func reset", rsp.data, 32'h0000_0000);
    check("select kept", 32'(revision_select_bit), 32'h0);
    @(negedge ref_clk);
    rd(8'h44, 1'b1, cap_dword(1'b0));
    arst_n = 1'b0;
    @(negedge ref_clk);
    check("valid in reset", 32'(rsp.valid), 32'h0);
    check("select on fundamental reset", 32'(revision_select_bit), 32'h1);
    arst_n = 1'b1;
    @(negedge ref_clk);
    rd(8'h44, 1'b1, cap_dword(1'b1));
    $display("test resets done");
  endtask

  task automatic test_unmapped;
    rd(8'h48, 1'b0, 32'h0000_0000);
    rd(8'h40, 1'b0, 32'h0000_0000);
    $display("test unmapped done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= 2000) begin
      mismatches++;
      $display("[ERR] timeout expected end seen hang");
      complete_run();
    end
  end

  initial begin
    mismatches  = 0;
    checks_done = 0;
    cycles      = 0;
    arst_n      = 1'b0;
    func_reset  = 1'b0;
    req         = '0;
    repeat (6) @(negedge ref_clk);
    arst_n = 1'b1;
    @(negedge ref_clk);
    test_reset_values();
    test_write_ignored();
    test_revision_select();
    test_resets();
    test_unmapped();
    complete_run();
  end
endmodule
